//--- hw/flc_consts.svh
// Register map, field positions, reset values and timing figures of the
// flash LED mode controller. Included by the top module.
`ifndef FLC_CONSTS_SVH
`define FLC_CONSTS_SVH

// Register byte offsets on the APB port.
`define FLC_OFS_ENABLE    8'h00
`define FLC_OFS_PRIVACY   8'h04
`define FLC_OFS_CONFIG1   8'h08
`define FLC_OFS_GPIO      8'h0C
`define FLC_OFS_TORCH_BR  8'h10
`define FLC_OFS_FLASH_BR  8'h14
`define FLC_OFS_FLASH_DUR 8'h18
`define FLC_OFS_STATUS    8'h1C

// Reset values.
`define FLC_RST_ENABLE    8'h18
`define FLC_RST_PRIVACY   8'h10
`define FLC_RST_CONFIG1   8'h60
`define FLC_RST_GPIO      8'h00
`define FLC_RST_TORCH_BR  8'h00
`define FLC_RST_FLASH_BR  8'h00
`define FLC_RST_FLASH_DUR 8'h0F

// Field values and positions.
`define FLC_MODE_OFF      2'b00
`define FLC_MODE_PRIV     2'b01
`define FLC_MODE_TORCH    2'b10
`define FLC_MODE_FLASH    2'b11
`define FLC_EN_LE_BIT     5
`define FLC_PRIV_TERM_BIT 3
`define FLC_CF1_HWFL_BIT  2
`define FLC_CF1_POL1_BIT  5
`define FLC_CF1_POL2_BIT  6
`define FLC_CF1_HWTO_BIT  7
`define FLC_GP_SEL1_BIT   0
`define FLC_GP_DIR1_BIT   1
`define FLC_GP_VAL1_BIT   2
`define FLC_GP_SEL2_BIT   3
`define FLC_GP_DIR2_BIT   4
`define FLC_GP_VAL2_BIT   5
`define FLC_GP_INT_BIT    6
`define FLC_TORCH_LEVELS  5'd8
`define FLC_PWM_SLOTS     4'd10

// Timing at a 100 MHz clock.
`define FLC_CLK_PERIOD_NS 10
`define FLC_RAMP_STEP_NS  32000
`define FLC_TOUT_STEP_MS  32
`define FLC_PWM_SLOT_NS   10000

`endif

//--- hw/flc_pkg.sv
// Types shared by the flash LED mode controller and its bench.
// Assumes flc_consts.svh sits on the include path.
`default_nettype none

package flc_pkg;

  // Operating state of the current sources.
  typedef enum logic [1:0] {
    FLC_OFF,
    FLC_PRIV,
    FLC_TORCH,
    FLC_FLASH
  } flc_state_t;

  // Drive to one current source: level 0..7 torch, 8..23 flash.
  typedef struct packed {
    logic       on;
    logic       flash;
    logic [4:0] level;
  } flc_led_t;

  // Drive of one two-way pin: level and output enable.
  typedef struct packed {
    logic o;
    logic oe;
  } flc_pin_drv_t;

endpackage : flc_pkg

`default_nettype wire

//--- hw/flc_mode_ctrl.sv
// Mode sequencing of a dual-channel flash LED driver, behind an APB port.
// Assumes a 100 MHz pclk and pins that are synchronous to it.
//
// Operation
// [RULE1] Mode 11 starts a flash sequence
// [RULE2] Mode 10 torch, ramps 32 us per level
// [RULE3] Mode 01 privacy on selected sources
// [RULE4] Mode 00 keeps both sources off
// [RULE5] Sources held off until output voltage ready
// [RULE6] Flash ramp through torch and flash levels
// [RULE7] Enable bits and brightness per source
// [RULE8] Two bits select switch current limit
// [RULE9] Sixteen flash levels set by brightness
// [RULE10] Trigger pin starts flash when enabled
// [RULE11] Level/edge one: only timeout ends flash
// [RULE12] Level/edge zero: pin low, mode 00, timeout
// [RULE13] Flash end: sources off, mode clears
// [RULE14] Privacy resumes after flash unless terminated
// [RULE15] Timeout 32 ms to 1024 ms steps
// [RULE16] Privacy PWM duty 10% to 80%
// [RULE17] First sync forces torch during flash
// [RULE18] First sync polarity bit, default high
// [RULE19] Hardware torch; flash wins, clears bit
// [RULE20] First pin as general-purpose I/O
// [RULE21] Second pin as I/O or interrupt
// [RULE22] Second sync polarity, forces torch
`default_nettype none

`include "flc_consts.svh"

module flc_mode_ctrl #(
  parameter int TOUT_UNIT_CYCLES = `FLC_TOUT_STEP_MS * 1000000 / `FLC_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic [31:0]            prdata,
  // Control pins
  input  wire logic              flash_trigger,
  input  wire logic              vout_ready,
  input  wire logic              int_condition,
  input  wire logic              first_multi_function_pin_i,
  output flc_pkg::flc_pin_drv_t  first_multi_function_pin_d,
  input  wire logic              second_multi_function_pin_i,
  output flc_pkg::flc_pin_drv_t  second_multi_function_pin_d,
  // Analog side
  output flc_pkg::flc_led_t      first_current_source,
  output flc_pkg::flc_led_t      second_current_source,
  output logic [1:0]             current_limit_sel
);

  localparam int RAMP_CYCLES = `FLC_RAMP_STEP_NS / `FLC_CLK_PERIOD_NS;
  localparam int PWM_CYCLES  = `FLC_PWM_SLOT_NS / `FLC_CLK_PERIOD_NS;

  // ---------------------------------------------------------------------
  // Registers and APB decode
  // ---------------------------------------------------------------------
  logic [7:0] enable_q;
  logic [7:0] privacy_q;
  logic [7:0] config1_q;
  logic [7:0] gpio_q;
  logic [7:0] torch_br_q;
  logic [7:0] flash_br_q;
  logic [7:0] flash_dur_q;
  logic [31:0] prdata_q;

  wire setup    = psel && !penable;
  wire access   = psel && penable;
  wire hit_en   = paddr == `FLC_OFS_ENABLE;
  wire hit_pr   = paddr == `FLC_OFS_PRIVACY;
  wire hit_c1   = paddr == `FLC_OFS_CONFIG1;
  wire hit_gp   = paddr == `FLC_OFS_GPIO;
  wire hit_tb   = paddr == `FLC_OFS_TORCH_BR;
  wire hit_fb   = paddr == `FLC_OFS_FLASH_BR;
  wire hit_fd   = paddr == `FLC_OFS_FLASH_DUR;
  wire hit_st   = paddr == `FLC_OFS_STATUS;
  wire mapped   = hit_en | hit_pr | hit_c1 | hit_gp | hit_tb | hit_fb | hit_fd | hit_st;
  wire wr       = access && pwrite && mapped;
  wire wr_en    = wr && hit_en;
  wire [1:0] wr_mode = pwdata[1:0];

  assign pready  = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata  = prdata_q;

  // ---------------------------------------------------------------------
  // Field views
  // ---------------------------------------------------------------------
  wire [1:0] mode      = enable_q[1:0];
  wire       src1_en   = enable_q[3];
  wire       src2_en   = enable_q[4];
  wire       level_sel = enable_q[`FLC_EN_LE_BIT];
  wire [2:0] duty_code = privacy_q[2:0];
  wire       priv_term = privacy_q[`FLC_PRIV_TERM_BIT];
  wire       priv_sel1 = privacy_q[4];
  wire       priv_sel2 = privacy_q[5];
  wire       hw_flash  = config1_q[`FLC_CF1_HWFL_BIT];
  wire       pol1      = config1_q[`FLC_CF1_POL1_BIT];
  wire       pol2      = config1_q[`FLC_CF1_POL2_BIT];
  wire       hw_torch  = config1_q[`FLC_CF1_HWTO_BIT];
  wire       gp_sel1   = gpio_q[`FLC_GP_SEL1_BIT];
  wire       gp_dir1   = gpio_q[`FLC_GP_DIR1_BIT];
  wire       gp_sel2   = gpio_q[`FLC_GP_SEL2_BIT];
  wire       gp_dir2   = gpio_q[`FLC_GP_DIR2_BIT];
  wire       gp_int    = gpio_q[`FLC_GP_INT_BIT];
  wire [4:0] tout_code = flash_dur_q[4:0];

  // ---------------------------------------------------------------------
  // Pins
  // ---------------------------------------------------------------------
  logic trig_prev_q;
  wire  trig_rise  = flash_trigger && !trig_prev_q;
  wire  sync1_mode = !gp_sel1 && !hw_torch;
  wire  sync1_act  = sync1_mode && (first_multi_function_pin_i == pol1); // [RULE17] [RULE18]
  wire  sync2_act  = !gp_sel2 && (second_multi_function_pin_i == pol2); // [RULE22]
  wire  hwt_on     = !gp_sel1 && hw_torch && first_multi_function_pin_i; // [RULE19]
  wire  force_torch = sync1_act || sync2_act;

  // The first pin drives only as a GPIO output; the second, in interrupt
  // mode, behaves as open drain and pulls low while the condition holds.
  assign first_multi_function_pin_d.oe = gp_sel1 && gp_dir1; // [RULE20]
  assign first_multi_function_pin_d.o  = gpio_q[`FLC_GP_VAL1_BIT];
  wire   int_mode = gp_sel2 && gp_dir2 && gp_int; // [RULE21]
  assign second_multi_function_pin_d.oe = int_mode ? int_condition : (gp_sel2 && gp_dir2);
  assign second_multi_function_pin_d.o  = int_mode ? 1'b0 : gpio_q[`FLC_GP_VAL2_BIT];

  // ---------------------------------------------------------------------
  // Flash sequencing
  // ---------------------------------------------------------------------
  flc_pkg::flc_state_t state_q;
  flc_pkg::flc_state_t state_d;
  logic        by_pin_q;
  logic        priv_resume_q;
  logic [21:0] tout_div_q;
  logic [4:0]  tout_cnt_q;

  wire in_flash   = state_q == flc_pkg::FLC_FLASH;
  wire pin_start  = hw_flash && trig_rise; // [RULE10]
  wire flash_req  = (mode == `FLC_MODE_FLASH) || pin_start; // [RULE1]
  wire flash_go   = !in_flash && flash_req;
  wire tout_tick  = tout_div_q == 22'(TOUT_UNIT_CYCLES - 1);
  wire timed_out  = in_flash && tout_tick && (tout_cnt_q == tout_code); // [RULE15]
  wire pin_low    = by_pin_q && !flash_trigger;
  wire end_edge   = !level_sel && (pin_low || (wr_en && wr_mode == `FLC_MODE_OFF)); // [RULE12]
  wire flash_end  = in_flash && (timed_out || end_edge); // [RULE11]
  wire tout_clr   = flash_go || (!level_sel && in_flash && trig_rise); // [RULE12]

  always_comb
  begin
    state_d = flc_pkg::FLC_OFF; // [RULE4]
    if (flash_end)
    begin
      state_d = priv_resume_q ? flc_pkg::FLC_PRIV : flc_pkg::FLC_OFF; // [RULE13] [RULE14]
    end
    else if (in_flash || flash_req)
    begin
      state_d = flc_pkg::FLC_FLASH; // [RULE19]
    end
    else if (mode == `FLC_MODE_TORCH || hwt_on)
    begin
      state_d = flc_pkg::FLC_TORCH; // [RULE2]
    end
    else if (mode == `FLC_MODE_PRIV || state_q == flc_pkg::FLC_PRIV && mode == `FLC_MODE_OFF
             && priv_resume_q)
    begin
      state_d = flc_pkg::FLC_PRIV; // [RULE3]
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q       <= flc_pkg::FLC_OFF;
      by_pin_q      <= 1'b0;
      priv_resume_q <= 1'b0;
      trig_prev_q   <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      trig_prev_q <= flash_trigger;
      if (flash_go)
      begin
        by_pin_q      <= pin_start && mode != `FLC_MODE_FLASH;
        priv_resume_q <= !priv_term && (mode == `FLC_MODE_PRIV ||
                         state_q == flc_pkg::FLC_PRIV); // [RULE14]
      end
      else if (wr_en && wr_mode != `FLC_MODE_OFF && !in_flash)
      begin
        priv_resume_q <= 1'b0;
      end
    end
  end

  // Timeout counts 32 ms units; with level/edge zero a retrigger restarts both counters.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tout_div_q <= '0;
      tout_cnt_q <= '0;
    end
    else if (tout_clr || !in_flash)
    begin
      tout_div_q <= '0;
      tout_cnt_q <= '0;
    end
    else if (tout_tick)
    begin
      tout_div_q <= '0;
      tout_cnt_q <= tout_cnt_q + 5'd1; // [RULE15]
    end
    else
    begin
      tout_div_q <= tout_div_q + 22'd1;
    end
  end

  // ---------------------------------------------------------------------
  // Level ramp
  // ---------------------------------------------------------------------
  logic [11:0] ramp_div_q;
  logic [4:0]  step1_q;
  logic [4:0]  step2_q;
  wire ramp_tick = ramp_div_q == 12'(RAMP_CYCLES - 1);
  wire at_flash  = in_flash && !force_torch;
  wire at_torch  = in_flash || state_q == flc_pkg::FLC_TORCH;

  // Rising targets climb one level per tick to limit inrush; falling
  // targets, such as a sync input forcing torch, are taken at once.
  function automatic logic [4:0] ramp_next(input logic [4:0] cur, input logic [4:0] tgt,
                                           input logic active, input logic tick);
    logic [4:0] nxt;
    nxt = cur;
    if (!active)
      nxt = 5'd0;
    else if (cur > tgt)
      nxt = tgt;
    else if (tick && cur < tgt)
      nxt = cur + 5'd1;
    return nxt;
  endfunction

  // Conditions come in as arguments so callers re-evaluate when the state moves.
  function automatic logic [4:0] target(input logic [2:0] torch, input logic [3:0] flash,
                                        input logic at_flash, input logic at_torch);
    return at_flash ? `FLC_TORCH_LEVELS + {1'b0, flash} : // [RULE6] [RULE9]
           at_torch ? {2'b00, torch} : 5'd0; // [RULE2] [RULE17] [RULE22]
  endfunction

  wire priv_on = state_q == flc_pkg::FLC_PRIV;
  wire act1 = vout_ready && (priv_on ? priv_sel1 : (state_q != flc_pkg::FLC_OFF && src1_en));
  wire act2 = vout_ready && (priv_on ? priv_sel2 : (state_q != flc_pkg::FLC_OFF && src2_en));
  wire [4:0] tgt1 = target(torch_br_q[2:0], flash_br_q[3:0], at_flash, at_torch); // [RULE7]
  wire [4:0] tgt2 = target(torch_br_q[5:3], flash_br_q[7:4], at_flash, at_torch);
  wire [4:0] step1_d = ramp_next(step1_q, tgt1, act1, ramp_tick); // [RULE5] [RULE6]
  wire [4:0] step2_d = ramp_next(step2_q, tgt2, act2, ramp_tick);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ramp_div_q <= '0;
      step1_q    <= '0;
      step2_q    <= '0;
    end
    else
    begin
      ramp_div_q <= ramp_tick ? 12'd0 : ramp_div_q + 12'd1;
      step1_q    <= step1_d;
      step2_q    <= step2_d;
    end
  end

  // ---------------------------------------------------------------------
  // Privacy PWM on the lowest torch level
  // ---------------------------------------------------------------------
  logic [9:0] pwm_div_q;
  logic [3:0] pwm_slot_q;
  wire pwm_tick = pwm_div_q == 10'(PWM_CYCLES - 1);
  wire pwm_high = pwm_slot_q <= {1'b0, duty_code}; // [RULE16]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pwm_div_q  <= '0;
      pwm_slot_q <= '0;
    end
    else if (pwm_tick)
    begin
      pwm_div_q  <= '0;
      pwm_slot_q <= (pwm_slot_q == `FLC_PWM_SLOTS - 4'd1) ? 4'd0 : pwm_slot_q + 4'd1;
    end
    else
    begin
      pwm_div_q <= pwm_div_q + 10'd1;
    end
  end

  // ---------------------------------------------------------------------
  // Register writes and hardware updates
  // ---------------------------------------------------------------------
  // A software write to the enable register in the cycle a flash ends wins
  // over the automatic clear, so a fresh command is never lost.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable_q    <= `FLC_RST_ENABLE;
      privacy_q   <= `FLC_RST_PRIVACY;
      config1_q   <= `FLC_RST_CONFIG1;
      gpio_q      <= `FLC_RST_GPIO;
      torch_br_q  <= `FLC_RST_TORCH_BR;
      flash_br_q  <= `FLC_RST_FLASH_BR;
      flash_dur_q <= `FLC_RST_FLASH_DUR;
    end
    else
    begin
      if (wr_en)
        enable_q <= pwdata[7:0];
      else if (flash_end)
        enable_q[1:0] <= `FLC_MODE_OFF; // [RULE13]
      if (wr && hit_pr)
        privacy_q <= pwdata[7:0];
      if (wr && hit_c1)
        config1_q <= pwdata[7:0];
      if (flash_go)
        config1_q[`FLC_CF1_HWTO_BIT] <= 1'b0; // [RULE19]
      if (wr && hit_gp)
        gpio_q <= pwdata[7:0];
      if (wr && hit_tb)
        torch_br_q <= pwdata[7:0];
      if (wr && hit_fb)
        flash_br_q <= pwdata[7:0];
      if (wr && hit_fd)
        flash_dur_q <= pwdata[7:0];
    end
  end

  // ---------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------
  wire pin1_rd = gp_dir1 ? gpio_q[`FLC_GP_VAL1_BIT] : first_multi_function_pin_i; // [RULE20]
  wire pin2_rd = gp_dir2 ? gpio_q[`FLC_GP_VAL2_BIT] : second_multi_function_pin_i; // [RULE21]
  wire [7:0] gpio_rd = {gpio_q[7:6], pin2_rd, gpio_q[4:3], pin1_rd, gpio_q[1:0]};
  wire [15:0] status_rd = {1'b0, force_torch, step2_q, step1_q, vout_ready,
                           priv_on, state_q == flc_pkg::FLC_TORCH, in_flash};
  wire [31:0] rd_mux = hit_en ? {24'h00_0000, enable_q} :
                       hit_pr ? {24'h00_0000, privacy_q} :
                       hit_c1 ? {24'h00_0000, config1_q} :
                       hit_gp ? {24'h00_0000, gpio_rd} :
                       hit_tb ? {24'h00_0000, torch_br_q} :
                       hit_fb ? {24'h00_0000, flash_br_q} :
                       hit_fd ? {24'h00_0000, flash_dur_q} :
                       hit_st ? {16'h0000, status_rd} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= '0;
    else if (setup && !pwrite)
      prdata_q <= rd_mux;
  end

  // ---------------------------------------------------------------------
  // Source drive
  // ---------------------------------------------------------------------
  logic [6:0] first_current_source_q;
  logic [6:0] second_current_source_q;
  // Level takes the next ramp value and the flash flag the current state, so a flash ramp flags torch levels as flash.

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      first_current_source_q <= '0;
      second_current_source_q <= '0;
    end
    else
    begin
      first_current_source_q <= {act1 && (!priv_on || pwm_high), at_flash && act1, step1_d}; // [RULE16]
      second_current_source_q <= {act2 && (!priv_on || pwm_high), at_flash && act2, step2_d};
    end
  end

  assign first_current_source  = first_current_source_q;
  assign second_current_source = second_current_source_q;
  assign current_limit_sel     = flash_dur_q[6:5]; // [RULE8]

endmodule // flc_mode_ctrl

`default_nettype wire

//--- dv/flc_host_pin.sv
// Host side of one two-way control pin of the flash LED mode controller.
// Assumes the design drive is a {o,oe} pair and the wire has no pull.
`default_nettype none

module flc_host_pin (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // Drives on the wire
  input  wire flc_pkg::flc_pin_drv_t drv,
  input  wire logic                  host_o,
  input  wire logic                  host_oe,
  // Resolved level
  output logic                       lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_q;

  // A released wire shows the inverse of its last level, so stale data is never read.
  assign lvl = drv.oe ? drv.o : (host_oe ? host_o : ~last_q);

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      last_q <= 1'b0;
    else
      last_q <= lvl;
endmodule // flc_host_pin

`default_nettype wire

//--- dv/flc_mode_ctrl_props.sv
// Concurrent checks on the ports of the flash LED mode controller.
// Assumes one pclk domain with presetn as its asynchronous reset.
`default_nettype none

module flc_mode_ctrl_props (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // APB
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  input  wire logic             pready,
  input  wire logic             pslverr,
  // Pins and sources
  input  wire logic             vout_ready,
  input  wire flc_pkg::flc_led_t first_current_source,
  input  wire flc_pkg::flc_led_t second_current_source,
  input  wire logic [1:0]       current_limit_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] l1_q;
  logic [4:0] l2_q;
  wire acc = psel && penable;
  wire unmapped = (paddr[1:0] != 2'b00) || (paddr > 8'h1C);
  wire rise1 = first_current_source.level > l1_q;
  wire rise2 = second_current_source.level > l2_q;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      l1_q <= 5'h00;
      l2_q <= 5'h00;
    end
    else
    begin
      l1_q <= first_current_source.level;
      l2_q <= second_current_source.level;
    end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  ready_always_a: assert property (pready) else $error("pready low");
  err_unmapped_a: assert property (acc && unmapped |-> pslverr) else $error("no pslverr");
  err_mapped_a: assert property (acc && !unmapped |-> !pslverr) else $error("stray pslverr");
  limit_follow_a: assert property (acc && pwrite && paddr == 8'h18 |=>
    current_limit_sel == $past(pwdata[6:5])) else $error("limit not taken");
  vout_hold_a: assert property (!vout_ready [*3] |->
    !first_current_source.on && !second_current_source.on) else $error("on before vout");
  step_one_a: assert property (first_current_source.on && rise1 |->
    first_current_source.level == l1_q + 5'd1) else $error("ramp skipped a level");
  step_gap_a: assert property (rise2 |=> !rise2 [*8]) else $error("ramp too fast");
  level_max_a: assert property (first_current_source.level <= 5'd23 &&
    second_current_source.level <= 5'd23) else $error("level beyond flash range");
  torch_range_a: assert property (first_current_source.on && !first_current_source.flash |->
    first_current_source.level <= 5'd7) else $error("torch level beyond range");
endmodule // flc_mode_ctrl_props

bind flc_mode_ctrl flc_mode_ctrl_props i_flc_mode_ctrl_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .vout_ready(vout_ready), .first_current_source(first_current_source),
  .second_current_source(second_current_source), .current_limit_sel(current_limit_sel)
);

`default_nettype wire

//--- dv/tb.sv
// Self-checking bench of the flash LED mode controller over APB and its pins.
// Assumes the design package, the host pin model and the checker are compiled first.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TU = 1200;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, rdv, prdata;
  logic pready, pslverr, err, pin1, pin2;
  logic flash_trigger = 0, vout_ready = 0, int_condition = 0, h1_o = 0, h2_o = 0;
  logic [1:0] lim;
  flc_pkg::flc_pin_drv_t d1, d2;
  flc_pkg::flc_led_t s1, s2;
  int miscompares = 0, n_checks = 0, cyc = 0, n, m;
  integer seed = 32'h8454646f;
  logic [7:0] rst_e [7] = '{8'h18, 8'h10, 8'h60, 8'h00, 8'h00, 8'h00, 8'h0F};

  always #5 pclk = ~pclk;

  flc_mode_ctrl #(.TOUT_UNIT_CYCLES(TU)) i_flc_mode_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .flash_trigger(flash_trigger), .vout_ready(vout_ready), .int_condition(int_condition),
    .first_multi_function_pin_i(pin1), .first_multi_function_pin_d(d1),
    .second_multi_function_pin_i(pin2), .second_multi_function_pin_d(d2),
    .first_current_source(s1), .second_current_source(s2), .current_limit_sel(lim));
  // The host drives both sync inputs, idle low, so flashes run at full level unless forced.
  flc_host_pin i_host1 (.pclk(pclk), .presetn(presetn), .drv(d1), .host_o(h1_o),
    .host_oe(1'b1), .lvl(pin1));
  flc_host_pin i_host2 (.pclk(pclk), .presetn(presetn), .drv(d2), .host_o(h2_o),
    .host_oe(1'b1), .lvl(pin2));

  // ---------------------------------------------------------------
  // Tasks and expectations
  // ---------------------------------------------------------------
  function automatic int pwm_on(input int k);
    return (k + 1) * 1000;
  endfunction

  function automatic logic [4:0] flash_lvl(input logic [3:0] c);
    return 5'd8 + 5'(c);
  endfunction

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] k);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdv & k, e & k);
  endtask

  task automatic wlvl(input logic [4:0] e1, input logic [4:0] e2);
    n = 0;
    while ((s1.level !== e1 || s2.level !== e2) && n < 40000)
    begin
      @(posedge pclk);
      n++;
    end
  endtask

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 100000)
    begin
      miscompares++;
      conclude();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rst_e[i])
      rchk(8'(i * 4), 32'(rst_e[i]), 32'hFFFF_FFFF);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk({err, rdv}, {1'b1, 32'h0000_0000});
    repeat (4)
    begin
      m = $random(seed);
      apb(1'b1, 8'h14, 32'(m));
      rchk(8'h14, 32'(m), 32'h0000_00FF);
      apb(1'b1, 8'h10, 32'(m >>> 8));
      rchk(8'h10, 32'(m >>> 8), 32'h0000_003F);
    end
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, 8'h18, 32'(i * 32 + 31));
      @(posedge pclk);
      chk(lim, 32'(i));
    end
    apb(1'b1, 8'h10, 32'h0000_0015);
    apb(1'b1, 8'h00, 32'h0000_001A);
    repeat (100) @(posedge pclk);
    chk(s1.on | s2.on, 0);
    vout_ready <= 1'b1;
    wlvl(5'd5, 5'd2);
    chk({s1.on, s1.flash, s1.level, s2.level}, {2'b10, 5'd5, 5'd2});
    apb(1'b1, 8'h00, 32'h0000_0018);
    repeat (3) @(posedge pclk);
    chk(s1.on | s2.on, 0);
    apb(1'b1, 8'h14, 32'h0000_0010);
    apb(1'b1, 8'h00, 32'h0000_001B);
    n = 0;
    m = 0;
    while ((n < 10 || s1.on === 1'b1) && n < 50000)
    begin
      @(posedge pclk);
      n++;
      if (s1.level === flash_lvl(4'h0) && s2.level === flash_lvl(4'h1) &&
          {s1.flash, s2.flash} === 2'b11)
        m = 1;
    end
    chk(m, 1);
    chk(n >= 30 * TU && n <= 34 * TU, 1);
    rchk(8'h00, 32'h0000_0018, 32'hFFFF_FFFF);
    chk(s2.on, 0);
    apb(1'b1, 8'h18, 32'h0000_0001);
    apb(1'b1, 8'h08, 32'h0000_00E4);
    flash_trigger <= 1'b1;
    repeat (100) @(posedge pclk);
    rchk(8'h1C, 32'h0000_0001, 32'h0000_0001);
    flash_trigger <= 1'b0;
    repeat (5) @(posedge pclk);
    rchk(8'h1C, 32'h0000_0000, 32'h0000_0001);
    rchk(8'h08, 32'h0000_0000, 32'h0000_0080);
    apb(1'b1, 8'h00, 32'h0000_0038);
    flash_trigger <= 1'b1;
    repeat (50) @(posedge pclk);
    flash_trigger <= 1'b0;
    h1_o <= 1'b1;
    repeat (200) @(posedge pclk);
    rchk(8'h1C, 32'h0000_4001, 32'h0000_4001);
    chk(s1.flash, 0);
    {h1_o, h2_o} <= 2'b01;
    repeat (3) @(posedge pclk);
    rchk(8'h1C, 32'h0000_4001, 32'h0000_4001);
    h2_o <= 1'b0;
    repeat (3 * TU) @(posedge pclk);
    rchk(8'h1C, 32'h0000_0000, 32'h0000_0001);
    apb(1'b1, 8'h04, 32'h0000_0012);
    apb(1'b1, 8'h00, 32'h0000_0019);
    repeat (100) @(posedge pclk);
    n = 0;
    m = 0;
    repeat (10000)
    begin
      @(posedge pclk);
      if (s1.on === 1'b1)
        n++;
      if (s2.on === 1'b1)
        m++;
    end
    chk(n >= pwm_on(2) - 20 && n <= pwm_on(2) + 20, 1);
    chk(m, 0);
    apb(1'b1, 8'h00, 32'h0000_001B);
    repeat (3 * TU) @(posedge pclk);
    rchk(8'h1C, 32'h0000_0004, 32'h0000_0007);
    rchk(8'h00, 32'h0000_0018, 32'h0000_00FF);
    apb(1'b1, 8'h00, 32'h0000_0018);
    apb(1'b1, 8'h0C, 32'h0000_0007);
    @(posedge pclk);
    chk(d1, 2'b11);
    apb(1'b1, 8'h0C, 32'h0000_0001);
    for (int v = 0; v < 2; v++)
    begin
      h1_o <= v[0];
      repeat (3) @(posedge pclk);
      rchk(8'h0C, 32'(v * 4), 32'h0000_0004);
    end
    apb(1'b1, 8'h0C, 32'h0000_0058);
    for (int v = 0; v < 2; v++)
    begin
      int_condition <= v[0];
      repeat (3) @(posedge pclk);
      chk(d2, {1'b0, v[0]});
    end
    conclude();
  end
endmodule // tb

`default_nettype wire
